// ==== src/fcs_regs.sv ====
// Purpose: Flash command/status registers and a small command sequencer.
// Assumes: Array model is a register array; BDM writes are a side port.
// Notes: Commands launch through the command-buffer-empty flag.
`timescale 1ns/100ps
// Behaviour
// - Config upper three bits RW, rest zero.
// - Key-write bit redirects key address writes.
// - Protection loaded from nonvolatile byte on first clock after reset.
// - Protection writes only increase protection.
// - Select field bounds protected high region.
// - Bit zero clear enables protection.
// - Status bits 3,1,0 read zero.
// - Writing one to buffer flag launches.
// - Only burst program may queue behind a running burst.
// - Complete flag set when idle, empty.
// - Protected target sets violation, command dropped.
// - Access error on bad sequence, divisor, stop.
// - Blank flag set on fully erased array.
// - Five command codes recognised.
// - Page erase 512 bytes; mass erase all.
// - Other codes raise access error.
// - Debug port may modify protection bits.
// - Program/erase disabled until divisor written.
// - Successful blank check unsecures device.
module fcs_regs
  import fcs_pkg::*;
#(
  parameter int ARRAY_BYTES = 1024,
  parameter int OP_COUNT = OP_CYCLES,
  parameter logic [7:0] DEVICE_INFO = 8'h5A
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus.
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Memory-space writes into the flash window.
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  // Debug access and system inputs.
  input wire logic dbg_prot_wr,
  input wire logic [7:0] dbg_prot_data,
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic stop_req,
  // Status outputs.
  output logic [1:0] security_state_code,
  output logic key_write_strobe,
  output logic [7:0] key_write_data,
  output logic busy
);
  localparam int AW = $clog2(ARRAY_BYTES);
  localparam int CW = $clog2(OP_COUNT + 1);

  logic [7:0] flash_mem [ARRAY_BYTES];
  logic [2:0] config_hi;
  logic [7:0] flash_protection;
  logic [7:0] flash_command;
  logic [7:0] clock_divisor_reg;
  logic divisor_loaded_flag;
  logic cmd_buffer_empty_flag, protection_violation_flag, access_error_flag;
  logic array_blank_flag;
  logic seq_pending;
  logic [15:0] pend_addr;
  logic [7:0] pend_data;
  logic buf_valid;
  logic [7:0] buf_cmd;
  logic [15:0] buf_addr;
  logic [7:0] buf_data;
  fcs_state_e state;
  logic [7:0] run_cmd;
  logic [15:0] run_addr;
  logic [7:0] run_data;
  logic [CW-1:0] op_cnt;
  logic [AW-1:0] scan_ptr;
  logic scan_ok;
  logic prot_loaded;
  logic stop_s1, stop_s2;

  function automatic logic is_legal(input logic [7:0] c);
    return (c == CMD_BLANK) || (c == CMD_BYTE_PROG) || (c == CMD_BURST_PROG) ||
      (c == CMD_PAGE_ERASE) || (c == CMD_MASS_ERASE);
  endfunction

  // Protected region is the high end above the select boundary.
  function automatic logic is_protected(input logic [7:0] p, input logic [15:0] a,
                                        input logic [7:0] c);
    logic [15:0] bound;
    bound = {p[7:1], 9'h1FF};
    return !p[0] && ((c == CMD_MASS_ERASE) || (a > bound));
  endfunction

  wire wr_cfg = bus_wr && (bus_addr == ADDR_CONFIG);
  wire wr_prot = bus_wr && (bus_addr == ADDR_PROT);
  wire wr_stat = bus_wr && (bus_addr == ADDR_STATUS);
  wire wr_cmd = bus_wr && (bus_addr == ADDR_CMD);
  wire wr_div = bus_wr && (bus_addr == ADDR_DIV);
  wire key_hit = mem_wr && (mem_addr >= KEY_BASE) && (mem_addr <= KEY_LAST);
  wire key_mode = config_hi[BIT_KEY_WRITE_ENABLE - 5];
  wire key_redirect = key_hit && key_mode;
  wire seq_write = mem_wr && !key_redirect;
  wire launch = wr_stat && bus_wdata[BIT_CBEF] && cmd_buffer_empty_flag;
  wire bad_seq = launch && !seq_pending;
  wire bad_code = launch && !is_legal(flash_command);
  wire no_div = launch && (flash_command != CMD_BLANK) && !divisor_loaded_flag;
  wire busy_other = launch && (state != FCS_IDLE) &&
    !((flash_command == CMD_BURST_PROG) && (run_cmd == CMD_BURST_PROG));
  wire acc_err_launch = bad_seq || bad_code || no_div || busy_other;
  wire viol_launch = launch && !acc_err_launch && (flash_command != CMD_BLANK) &&
    is_protected(flash_protection, pend_addr, flash_command);
  wire good_launch = launch && !acc_err_launch && !viol_launch;
  wire stop_err = stop_s2 && (state != FCS_IDLE);
  wire op_done = (state == FCS_RUN) && (op_cnt == CW'(OP_COUNT - 1));
  wire scan_end = (state == FCS_BLANK_SCAN) && (scan_ptr == AW'(ARRAY_BYTES - 1));
  wire cur_erased = flash_mem[scan_ptr] == ERASED_BYTE;
  wire take_buf = buf_valid && ((state == FCS_IDLE) || op_done);
  wire ccf_now = !buf_valid && (state == FCS_IDLE);
  wire [7:0] status_rd = {cmd_buffer_empty_flag, ccf_now, protection_violation_flag,
    access_error_flag, 1'b0, array_blank_flag, 2'b00} & STATUS_MASK;
  wire [7:0] prot_req = bus_wdata;
  wire prot_ok = !flash_protection[0] && !prot_req[0] &&
    (prot_req[7:1] <= flash_protection[7:1]);
  wire [7:0] next_rdata =
    (bus_addr == ADDR_CONFIG) ? ({config_hi, 5'h00} & CONFIG_MASK) :
    (bus_addr == ADDR_PROT) ? flash_protection :
    (bus_addr == ADDR_STATUS) ? status_rd :
    (bus_addr == ADDR_CMD) ? flash_command :
    (bus_addr == ADDR_DIV) ? {divisor_loaded_flag, clock_divisor_reg[6:0]} :
    (bus_addr == ADDR_ADDR_LO) ? pend_addr[7:0] :
    (bus_addr == ADDR_ADDR_HI) ? pend_addr[15:8] :
    (bus_addr == ADDR_DATA) ? pend_data :
    (bus_addr == ADDR_INFO) ? DEVICE_INFO : 8'h00; // Info value is arbitrary.

  always_ff @(posedge sys_clk) begin
    stop_s1 <= stop_req;
    stop_s2 <= stop_s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      config_hi <= 3'h0;
    end else if (wr_cfg) begin
      config_hi <= bus_wdata[7:5];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flash_protection <= 8'hFF;
      prot_loaded <= 1'b0;
    end else if (!prot_loaded) begin
      flash_protection <= nonvolatile_protection_byte;
      prot_loaded <= 1'b1;
    end else if (dbg_prot_wr) begin
      flash_protection <= dbg_prot_data;
    end else if (wr_prot && prot_ok) begin
      flash_protection <= prot_req;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_divisor_reg <= 8'h00;
      divisor_loaded_flag <= 1'b0;
    end else if (wr_div) begin
      clock_divisor_reg <= bus_wdata;
      divisor_loaded_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flash_command <= 8'h00;
    end else if (wr_cmd) begin
      flash_command <= bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seq_pending <= 1'b0;
      pend_addr <= 16'h0000;
      pend_data <= 8'h00;
    end else if (seq_write) begin
      seq_pending <= 1'b1;
      pend_addr <= mem_addr;
      pend_data <= mem_wdata;
    end else if (launch) begin
      seq_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      key_write_strobe <= 1'b0;
      key_write_data <= 8'h00;
    end else begin
      key_write_strobe <= key_redirect;
      key_write_data <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      protection_violation_flag <= 1'b0;
      access_error_flag <= 1'b0;
    end else begin
      if (viol_launch) begin
        protection_violation_flag <= 1'b1;
      end else if (wr_stat && bus_wdata[BIT_PVIOL]) begin
        protection_violation_flag <= 1'b0;
      end
      if (acc_err_launch || stop_err) begin
        access_error_flag <= 1'b1;
      end else if (wr_stat && bus_wdata[BIT_ACCERR]) begin
        access_error_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      array_blank_flag <= 1'b0;
    end else if (scan_end) begin
      array_blank_flag <= scan_ok && cur_erased;
    end else if (good_launch) begin
      array_blank_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      security_state_code <= SEC_SECURED;
    end else if (scan_end && scan_ok && cur_erased) begin
      security_state_code <= SEC_UNSECURED;
    end
  end

  // Buffer flag: cleared on launch, set once the buffered command leaves for the array or a stop aborts.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_buffer_empty_flag <= 1'b1;
      buf_valid <= 1'b0;
      buf_cmd <= 8'h00;
      buf_addr <= 16'h0000;
      buf_data <= 8'h00;
    end else if (good_launch && !stop_err) begin
      cmd_buffer_empty_flag <= 1'b0;
      buf_valid <= 1'b1;
      buf_cmd <= flash_command;
      buf_addr <= pend_addr;
      buf_data <= pend_data;
    end else if (take_buf || stop_err) begin
      cmd_buffer_empty_flag <= 1'b1;
      buf_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= FCS_IDLE;
      run_cmd <= 8'h00;
      run_addr <= 16'h0000;
      run_data <= 8'h00;
      op_cnt <= '0;
      scan_ptr <= '0;
      scan_ok <= 1'b1;
      busy <= 1'b0;
    end else begin
      busy <= !ccf_now;
      if (stop_err) begin
        state <= FCS_IDLE;
      end else if (take_buf) begin
        run_cmd <= buf_cmd;
        run_addr <= buf_addr;
        run_data <= buf_data;
        op_cnt <= '0;
        scan_ptr <= '0;
        scan_ok <= 1'b1;
        state <= (buf_cmd == CMD_BLANK) ? FCS_BLANK_SCAN : FCS_RUN;
      end else begin
        unique case (state)
          FCS_IDLE: begin
            op_cnt <= '0;
          end
          FCS_RUN: begin
            op_cnt <= op_done ? '0 : op_cnt + 1'b1;
            if (op_done) begin
              state <= FCS_IDLE;
            end
          end
          FCS_BLANK_SCAN: begin
            scan_ok <= scan_ok && cur_erased;
            scan_ptr <= scan_ptr + 1'b1;
            if (scan_end) begin
              state <= FCS_IDLE;
            end
          end
          default: state <= FCS_IDLE;
        endcase
      end
    end
  end

  // Array model: byte program clears bits, erase sets bytes to the erased value.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < ARRAY_BYTES; i++) begin
      if (op_done) begin
        if (run_cmd == CMD_MASS_ERASE) begin
          flash_mem[i] <= ERASED_BYTE;
        end else if ((run_cmd == CMD_PAGE_ERASE) &&
                     ((i / PAGE_BYTES) == (int'(run_addr[AW-1:0]) / PAGE_BYTES))) begin
          flash_mem[i] <= ERASED_BYTE;
        end else if (((run_cmd == CMD_BYTE_PROG) || (run_cmd == CMD_BURST_PROG)) &&
                     (i == int'(run_addr[AW-1:0]))) begin
          flash_mem[i] <= flash_mem[i] & run_data;
        end
      end
    end
  end

  flag_set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    viol_launch |=> protection_violation_flag) else $error("violation flag lost");
  launch_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (good_launch && !stop_err) |=> !cmd_buffer_empty_flag) else $error("buffer flag");
  bad_code_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bad_code |=> access_error_flag) else $error("illegal code not flagged");
  divisor_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !divisor_loaded_flag |-> !(good_launch && flash_command != CMD_BLANK))
    else $error("launch without divisor");
  prot_monotone_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prot_loaded && $past(prot_loaded) && !$past(dbg_prot_wr)) |->
    flash_protection[7:1] <= $past(flash_protection[7:1]))
    else $error("protection decreased");
  status_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_rd && bus_addr == ADDR_STATUS) |=> (bus_rdata & ~STATUS_MASK) == 8'h00)
    else $error("reserved status bits");
  config_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_rd && bus_addr == ADDR_CONFIG) |=> bus_rdata[4:0] == 5'h00)
    else $error("config low bits");
  key_redirect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (key_hit && key_mode) |-> !seq_write ##1 key_write_strobe) else $error("key write");
  unsecure_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (scan_end && scan_ok && cur_erased) |=> security_state_code == SEC_UNSECURED)
    else $error("not unsecured");
  complete_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (good_launch && !stop_err) |=> !ccf_now) else $error("complete flag");
  dbg_prot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prot_loaded && dbg_prot_wr) |=> flash_protection == $past(dbg_prot_data))
    else $error("debug protection write lost");
  prot_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (prot_loaded && flash_protection[0] && !dbg_prot_wr) |=> $stable(flash_protection))
    else $error("disabled protection changed");
  blank_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    good_launch |=> !array_blank_flag) else $error("blank flag not cleared");
  stop_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_err |=> (state == FCS_IDLE) && access_error_flag)
    else $error("stop did not abort");
endmodule // fcs_regs

// ==== include/fcs_pkg.sv ====
// Purpose: Shared constants for the flash command and status register block.
// Assumes: 8-bit register bus; offsets below are local word indices.
// Notes: Command codes and bit positions follow the register descriptions.
package fcs_pkg;
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_PROT = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CMD = 4'h3;
  localparam logic [3:0] ADDR_DIV = 4'h4;
  localparam logic [3:0] ADDR_ADDR_LO = 4'h5;
  localparam logic [3:0] ADDR_ADDR_HI = 4'h6;
  localparam logic [3:0] ADDR_DATA = 4'h7;
  localparam logic [3:0] ADDR_INFO = 4'h8;

  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

  localparam int BIT_CBEF = 7;
  localparam int BIT_CCF = 6;
  localparam int BIT_PVIOL = 5;
  localparam int BIT_ACCERR = 4;
  localparam int BIT_BLANK = 2;
  localparam int BIT_KEY_WRITE_ENABLE = 5;

  localparam logic [7:0] CONFIG_MASK = 8'hE0;
  localparam logic [7:0] STATUS_MASK = 8'hF4;
  localparam logic [7:0] W1C_MASK = 8'h30;
  localparam logic [15:0] KEY_BASE = 16'hFFB0;
  localparam logic [15:0] KEY_LAST = 16'hFFB7;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] SEC_SECURED = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_BYTES = 512;

  localparam real OP_TIME_US = 20.0;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int OP_CYCLES = int'(OP_TIME_US * 1000.0 / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    FCS_IDLE,
    FCS_RUN,
    FCS_BLANK_SCAN
  } fcs_state_e;
endpackage

// ==== tb/fcs_regs_test.sv ====
// Purpose: Self-checking bench for the flash command and status registers.
// Assumes: OP_COUNT shortened to 40 cycles; blank scan takes about ARRAY_BYTES cycles.
// Notes: Each scenario is one task that drives the block and judges the results.
`timescale 1ns/100ps
module fcs_regs_test
  import fcs_pkg::*;
;
  logic sys_clk, rst_n, bus_wr, bus_rd, mem_wr, dbg_prot_wr, stop_req, key_write_strobe, busy;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, mem_wdata, dbg_prot_data, nv_byte, key_write_data, rv;
  logic [15:0] mem_addr;
  logic [1:0] security_state_code;
  int failures, cmp_count;

  fcs_regs #(.OP_COUNT(40)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .dbg_prot_wr(dbg_prot_wr),
    .dbg_prot_data(dbg_prot_data), .nonvolatile_protection_byte(nv_byte),
    .stop_req(stop_req), .security_state_code(security_state_code),
    .key_write_strobe(key_write_strobe), .key_write_data(key_write_data), .busy(busy)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    rv = bus_rdata;
    chk(rv & m, e);
  endtask

  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge sys_clk);
    mem_wr <= 1'b0;
  endtask

  task automatic launch(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    mw(a, d);
    wr(ADDR_CMD, c);
    wr(ADDR_STATUS, 8'h80);
  endtask

  // Polls the complete flag under a bounded count, then checks the whole status.
  task automatic done(input logic [7:0] e);
    int i;
    for (i = 0; i < 1500; i++) begin
      rc(ADDR_STATUS, 8'h0B, 8'h00);
      if (rv[BIT_CCF] === 1'b1) break;
    end
    rc(ADDR_STATUS, 8'hFF, e);
  endtask

  task automatic t_reset;
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    rc(ADDR_CONFIG, 8'hFF, 8'h00);
    rc(ADDR_PROT, 8'hFF, 8'h80);
    chk({6'h00, security_state_code}, {6'h00, SEC_SECURED});
    $display("test reset done");
  endtask

  task automatic t_masks;
    wr(ADDR_CONFIG, 8'hFF);
    rc(ADDR_CONFIG, 8'hFF, 8'hE0);
    wr(ADDR_CONFIG, 8'h00);
    rc(ADDR_CONFIG, 8'hFF, 8'h00);
    wr(ADDR_STATUS, 8'h4F);
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    $display("test masks done");
  endtask

  task automatic t_errors;
    launch(16'h0010, 8'h00, CMD_BYTE_PROG);
    done(8'hD0);
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'hFF, 8'hD0);
    wr(ADDR_STATUS, 8'h10);
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    wr(ADDR_DIV, 8'h31);
    rc(ADDR_DIV, 8'h80, 8'h80);
    launch(16'h0010, 8'h00, 8'h33);
    done(8'hD0);
    wr(ADDR_STATUS, 8'h10);
    $display("test errors done");
  endtask

  task automatic t_protect;
    wr(ADDR_PROT, 8'h90);
    rc(ADDR_PROT, 8'hFF, 8'h80);
    wr(ADDR_PROT, 8'h40);
    rc(ADDR_PROT, 8'hFF, 8'h40);
    launch(16'h4200, 8'h00, CMD_BYTE_PROG);
    done(8'hE0);
    wr(ADDR_STATUS, 8'h20);
    launch(16'h0000, 8'h00, CMD_MASS_ERASE);
    done(8'hE0);
    wr(ADDR_STATUS, 8'h20);
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    @(posedge sys_clk);
    dbg_prot_wr <= 1'b1;
    dbg_prot_data <= 8'hFF;
    @(posedge sys_clk);
    dbg_prot_wr <= 1'b0;
    rc(ADDR_PROT, 8'hFF, 8'hFF);
    wr(ADDR_PROT, 8'h00);
    rc(ADDR_PROT, 8'hFF, 8'hFF);
    $display("test protect done");
  endtask

  task automatic t_erase;
    launch(16'h0000, 8'h00, CMD_MASS_ERASE);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({7'h00, busy}, 8'h01);
    done(8'hC0);
    chk({7'h00, busy}, 8'h00);
    launch(16'h0000, 8'h00, CMD_BLANK);
    done(8'hC4);
    chk({6'h00, security_state_code}, {6'h00, SEC_UNSECURED});
    launch(16'h0005, 8'h00, CMD_BYTE_PROG);
    done(8'hC0);
    launch(16'h0200, 8'h00, CMD_BYTE_PROG);
    done(8'hC0);
    launch(16'h0000, 8'h00, CMD_PAGE_ERASE);
    done(8'hC0);
    launch(16'h0000, 8'h00, CMD_BLANK);
    done(8'hC0);
    launch(16'h0200, 8'h00, CMD_PAGE_ERASE);
    done(8'hC0);
    launch(16'h0000, 8'h00, CMD_BLANK);
    done(8'hC4);
    $display("test erase done");
  endtask

  task automatic t_burst;
    launch(16'h0010, 8'h0F, CMD_BURST_PROG);
    launch(16'h0011, 8'hF0, CMD_BURST_PROG);
    rc(ADDR_STATUS, 8'hD0, 8'h00);
    done(8'hC0);
    launch(16'h0000, 8'h00, CMD_BLANK);
    launch(16'h0012, 8'h00, CMD_BYTE_PROG);
    done(8'hD0);
    wr(ADDR_STATUS, 8'h10);
    launch(16'h0000, 8'h00, CMD_BLANK);
    @(posedge sys_clk);
    stop_req <= 1'b1;
    repeat (6) @(posedge sys_clk);
    stop_req <= 1'b0;
    done(8'hD0);
    wr(ADDR_STATUS, 8'h10);
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    $display("test burst and stop done");
  endtask

  task automatic t_key;
    logic [7:0] got;
    got = 8'h00;
    wr(ADDR_CONFIG, 8'h20);
    mw(16'hFFB3, 8'hA5);
    for (int i = 0; i < 3; i++) begin
      #1;
      if (key_write_strobe === 1'b1) got = key_write_data;
      @(posedge sys_clk);
    end
    chk(got, 8'hA5);
    rc(ADDR_STATUS, 8'hFF, 8'hC0);
    rc(ADDR_ADDR_HI, 8'hFF, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    mw(16'hFFB3, 8'h5C);
    rc(ADDR_ADDR_LO, 8'hFF, 8'hB3);
    $display("test key done");
  endtask

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    give_verdict;
  end

  initial begin
    rst_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    mem_wr = 1'b0;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
    dbg_prot_wr = 1'b0;
    dbg_prot_data = 8'h00;
    nv_byte = 8'h80;
    stop_req = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_masks;
    t_errors;
    t_protect;
    t_erase;
    t_burst;
    t_key;
    give_verdict;
  end
endmodule // fcs_regs_test
